// ==== hw/ulh_link.sv ====
`timescale 1ns/1ps
module ulh_link (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire ulh_pkg::ulh_addr_t PADDR,
   input wire ulh_pkg::ulh_word_t PWDATA,
   output ulh_pkg::ulh_word_t PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic ULPI_CLK_I,
   output logic ULPI_CLK_O,
   output logic ULPI_CLK_OE,
   input wire logic ULPI_DIR,
   input wire logic ULPI_NXT,
   input wire ulh_pkg::ulh_byte_t ULPI_DATA_I,
   output ulh_pkg::ulh_byte_t ULPI_DATA_O,
   output logic ULPI_DATA_OE,
   output logic ULPI_STP
);
   import ulh_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic needs_ext(input ulh_byte_t a);
      return (a[7:6] != 2'h0) || (a[5:0] == EXT_ADDR);
   endfunction

   function automatic ulh_byte_t cmd_byte(input ulh_cmd_t c);
      if (c.op == OP_TX) begin
         return {OP_TX, 2'h0, c.addr[3:0]};
      end
      if (needs_ext(c.addr)) begin
         return {c.op, EXT_ADDR};
      end
      return {c.op, c.addr[5:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   ulh_pins_t pins_raw;
   ulh_pins_t s1_reg;
   ulh_pins_t s2_reg;
   ulh_pins_t s3_reg;
   logic [$bits(ulh_pins_t)-1:0] filt_bits;
   ulh_pins_t filt;

   assign pins_raw = '{clk: ULPI_CLK_I, dir: ULPI_DIR, nxt: ULPI_NXT, data: ULPI_DATA_I};
   assign filt = filt_bits;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else if (CE) begin
         s1_reg <= pins_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   logic [$bits(ulh_pins_t)-1:0] agree;

   genvar gi;
   generate
      for (gi = 0; gi < $bits(ulh_pins_t); gi++) begin : g_filt
         assign agree[gi] = (s2_reg[gi] == s3_reg[gi]);
      end
   endgenerate

   // a bit follows stage three only once stages two and three agree
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         filt_bits <= '0;
      end else if (CE) begin
         filt_bits <= (filt_bits & ~agree) | (s3_reg & agree);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register and ULPI clock

   logic src_phy_reg;
   logic clk_stop_reg;
   logic wake_reg;
   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic clk_o_reg;
   logic clk_last_reg;
   logic running;
   logic own_tick;
   logic phy_rise;
   logic tick;

   assign running = ~src_phy_reg & ~clk_stop_reg;
   assign div_next = (div_reg == ULPI_DIV_LAST) ? 3'h0 : div_reg + 3'h1;
   assign own_tick = running & (div_reg == ULPI_DIV_LAST);
   assign phy_rise = filt.clk & ~clk_last_reg;
   assign tick = CE & (src_phy_reg ? phy_rise : own_tick);

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         div_reg <= 3'h0;
         clk_o_reg <= 1'b0;
         clk_last_reg <= 1'b0;
      end else if (CE) begin
         div_reg <= running ? div_next : 3'h0;
         clk_o_reg <= running && (div_next >= ULPI_HI_FIRST) && (div_next <= ULPI_HI_LAST);
         clk_last_reg <= filt.clk;
      end
   end

   assign ULPI_CLK_O = clk_o_reg;
   assign ULPI_CLK_OE = ~src_phy_reg;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave

   logic sel_ctrl;
   logic sel_cmd;
   logic sel_status;
   logic mapped;
   logic apb_wr;
   logic apb_setup;
   logic busy_reg;
   logic cmd_wr_ok;
   logic done_reg;
   logic rxv_reg;
   ulh_byte_t rdata_reg;
   ulh_byte_t rxcmd_reg;
   ulh_word_t prdata_reg;
   ulh_word_t rd_mux;
   ulh_word_t status_word;

   assign sel_ctrl = (PADDR == REG_CTRL);
   assign sel_cmd = (PADDR == REG_CMD);
   assign sel_status = (PADDR == REG_STATUS);
   assign mapped = sel_ctrl | sel_cmd | sel_status;
   assign apb_wr = PSEL & PENABLE & PWRITE;
   assign apb_setup = PSEL & ~PENABLE;
   assign cmd_wr_ok = apb_wr & sel_cmd & ~busy_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & (~mapped | (sel_cmd & PWRITE & busy_reg));

   assign status_word = {8'h00, rxcmd_reg, rdata_reg, 4'h0, filt.dir, rxv_reg, done_reg, busy_reg};
   assign rd_mux = sel_ctrl ? {29'h0, wake_reg, clk_stop_reg, src_phy_reg} :
                   sel_status ? status_word : 32'h0000_0000;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         prdata_reg <= 32'h0000_0000;
         src_phy_reg <= CTRL_RST_VAL;
         clk_stop_reg <= CTRL_RST_VAL;
         wake_reg <= CTRL_RST_VAL;
      end else if (CE) begin
         if (apb_setup) begin
            prdata_reg <= rd_mux;
         end
         if (apb_wr && sel_ctrl) begin
            src_phy_reg <= PWDATA[CTRL_SRC_PHY];
            clk_stop_reg <= PWDATA[CTRL_CLK_STOP];
            wake_reg <= PWDATA[CTRL_WAKE];
         end
      end
   end

   assign PRDATA = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // ULPI link state machine

   ulh_state_t state_reg;
   ulh_state_t state_next;
   ulh_cmd_t cmd_reg;
   ulh_byte_t data_reg;
   ulh_byte_t data_next;
   logic stp_reg;
   logic stp_next;
   logic dir_last_reg;
   logic oe_reg;
   logic turn;
   logic fin;
   logic capture;
   logic rx_cap;
   logic done_clr;
   logic rxv_clr;
   logic ext_needed;

   assign turn = filt.dir ^ dir_last_reg;
   assign ext_needed = (cmd_reg.op != OP_TX) && needs_ext(cmd_reg.addr);
   assign rx_cap = tick & filt.dir & ~turn & (state_reg != ST_RD_DATA);
   assign done_clr = apb_wr & sel_status & PWDATA[STS_DONE];
   assign rxv_clr = apb_wr & sel_status & PWDATA[STS_RXV];

   always_comb begin
      state_next = state_reg;
      data_next = data_reg;
      stp_next = stp_reg;
      fin = 1'b0;
      capture = 1'b0;
      if (tick) begin
         stp_next = 1'b0;
         case (state_reg)
            ST_IDLE: begin
               data_next = IDLE_BYTE;
               if (busy_reg && !filt.dir && !dir_last_reg) begin
                  data_next = cmd_byte(cmd_reg);
                  state_next = ST_CMD;
               end
            end
            ST_CMD: begin
               if (filt.dir) begin
                  data_next = IDLE_BYTE;
                  state_next = ST_IDLE;
               end else if (filt.nxt) begin
                  if (ext_needed) begin
                     data_next = cmd_reg.addr;
                     state_next = ST_EXT;
                  end else if (cmd_reg.op == OP_RD) begin
                     data_next = IDLE_BYTE;
                     state_next = ST_RD_TURN;
                  end else begin
                     data_next = cmd_reg.wdata;
                     state_next = ST_DATA;
                  end
               end
            end
            ST_EXT: begin
               if (filt.dir) begin
                  data_next = IDLE_BYTE;
                  state_next = ST_IDLE;
               end else if (filt.nxt) begin
                  if (cmd_reg.op == OP_RD) begin
                     data_next = IDLE_BYTE;
                     state_next = ST_RD_TURN;
                  end else begin
                     data_next = cmd_reg.wdata;
                     state_next = ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (filt.dir) begin
                  data_next = IDLE_BYTE;
                  state_next = ST_IDLE;
               end else if (filt.nxt) begin
                  data_next = IDLE_BYTE;
                  stp_next = 1'b1;
                  state_next = ST_STOP;
               end
            end
            ST_STOP: begin
               fin = 1'b1;
               state_next = ST_IDLE;
            end
            ST_RD_TURN: begin
               if (filt.dir && turn) begin
                  state_next = ST_RD_DATA;
               end
            end
            ST_RD_DATA: begin
               if (filt.dir && !turn) begin
                  capture = 1'b1;
                  fin = 1'b1;
                  state_next = ST_IDLE;
               end else if (!filt.dir) begin
                  state_next = ST_IDLE;
               end
            end
            default: begin
               data_next = IDLE_BYTE;
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_reg <= ST_IDLE;
         data_reg <= IDLE_BYTE;
         stp_reg <= 1'b0;
         dir_last_reg <= 1'b1;
         oe_reg <= 1'b0;
      end else if (CE) begin
         state_reg <= state_next;
         data_reg <= data_next;
         stp_reg <= stp_next;
         oe_reg <= ~filt.dir & ~dir_last_reg;
         if (tick) begin
            dir_last_reg <= filt.dir;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cmd_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         rxv_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rxcmd_reg <= 8'h00;
      end else if (CE) begin
         if (cmd_wr_ok) begin
            cmd_reg <= '{op: PWDATA[CMD_OP_LSB +: 2], addr: PWDATA[CMD_ADDR_LSB +: 8],
                         wdata: PWDATA[CMD_WDATA_LSB +: 8]};
         end
         busy_reg <= cmd_wr_ok | (busy_reg & ~fin);
         done_reg <= fin | (done_reg & ~done_clr);
         rxv_reg <= rx_cap | (rxv_reg & ~rxv_clr);
         if (capture) begin
            rdata_reg <= filt.data;
         end
         if (rx_cap) begin
            rxcmd_reg <= filt.data;
         end
      end
   end

   assign ULPI_DATA_O = data_reg;
   assign ULPI_DATA_OE = oe_reg;
   assign ULPI_STP = stp_reg | wake_reg;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST || !CE);

   sequence s_clk_high;
      ULPI_CLK_O [*3];
   endsequence

   sequence s_clk_low;
      !ULPI_CLK_O [*3];
   endsequence

   a_clk_own_period: assert property (disable iff (RST || !CE || !running)
      $rose(ULPI_CLK_O) |-> s_clk_high ##1 s_clk_low)
      else $error("own ulpi clock period wrong");
   a_release_on_dir: assert property (filt.dir |=> !ULPI_DATA_OE)
      else $error("data bus driven while direction high");
   a_turn_no_drive: assert property ((tick && turn) |=> !ULPI_DATA_OE)
      else $error("data bus driven in turn-around");
   a_start_dir_low: assert property ((state_reg == ST_IDLE && state_next == ST_CMD) |-> !filt.dir)
      else $error("command started while direction high");
   a_cmd_nonzero: assert property ((state_reg == ST_CMD) |-> data_reg != IDLE_BYTE)
      else $error("command byte is zero");
   a_stop_after_data: assert property (
      (tick && state_reg == ST_DATA && filt.nxt && !filt.dir) |=> (stp_reg && data_reg == IDLE_BYTE))
      else $error("stop not raised after last byte");
   a_stop_one_tick: assert property ($rose(stp_reg) |-> stp_reg until_with tick)
      else $error("stop dropped before next ulpi edge");
   a_stop_falls: assert property ((stp_reg && tick) |=> !stp_reg)
      else $error("stop longer than one ulpi cycle");
   a_next_byte: assert property (
      (tick && state_reg == ST_CMD && filt.nxt && !filt.dir && !ext_needed && cmd_reg.op != OP_RD)
      |=> data_reg == cmd_reg.wdata)
      else $error("next byte not presented");
   a_rd_turn_ignore: assert property ((tick && turn) |=> $stable(rdata_reg))
      else $error("read data taken in turn-around");
   a_idle_after_wr: assert property ((state_reg == ST_STOP) |-> data_reg == IDLE_BYTE)
      else $error("bus not idle after write");

endmodule

// ==== hw/ulh_pkg.sv ====
// Summary of operation
// - all pins driven and sampled at the ULPI clock rising edge, single rate.
// - ULPI clock comes either from this link or from the transceiver.
// - transceiver owns the data bus while direction is high, link while low.
// - a non-zero byte starts a transfer; zero means idle.
// - link pulses stop for exactly one ULPI clock to end a stream.
// - when link sends, stop marks the previous byte as the last one.
// - after next is seen, link presents the following byte next cycle.
// - one turn-around cycle with no driver on each direction change.
// - asynchronous modes stop the clock and redefine the bus pins; here CTRL_CLK_STOP only halts the own clock, bus pins unchanged.
// - link uses stop to end transfers and to wake the transceiver.
// - link starts a register access only while direction is low.
// - command bits 7:6 select idle, transmit, write, read; 101111b extends.
// - after a register write the link returns the bus to 00h.
package ulh_pkg;

   typedef logic [11:0] ulh_addr_t;
   typedef logic [31:0] ulh_word_t;
   typedef logic [7:0] ulh_byte_t;

   typedef struct packed {
      logic clk;
      logic dir;
      logic nxt;
      logic [7:0] data;
   } ulh_pins_t;

   typedef struct packed {
      logic [1:0] op;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ulh_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_EXT = 3'b010,
      ST_DATA = 3'b011,
      ST_STOP = 3'b100,
      ST_RD_TURN = 3'b101,
      ST_RD_DATA = 3'b110
   } ulh_state_t;

   // register offsets
   localparam ulh_addr_t REG_CTRL = 12'h000;
   localparam ulh_addr_t REG_CMD = 12'h004;
   localparam ulh_addr_t REG_STATUS = 12'h008;

   // control fields
   localparam int CTRL_SRC_PHY = 0;
   localparam int CTRL_CLK_STOP = 1;
   localparam int CTRL_WAKE = 2;
   localparam logic CTRL_RST_VAL = 1'b0;

   // command fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_WDATA_LSB = 16;

   // status fields
   localparam int STS_BUSY = 0;
   localparam int STS_DONE = 1;
   localparam int STS_RXV = 2;
   localparam int STS_DIR = 3;
   localparam int STS_RDATA_LSB = 8;
   localparam int STS_RXCMD_LSB = 16;

   // command byte encoding
   localparam logic [1:0] OP_IDLE = 2'h0;
   localparam logic [1:0] OP_TX = 2'h1;
   localparam logic [1:0] OP_WR = 2'h2;
   localparam logic [1:0] OP_RD = 2'h3;
   localparam logic [5:0] EXT_ADDR = 6'h2F;
   localparam ulh_byte_t IDLE_BYTE = 8'h00;

   // own ULPI clock: period in core cycles, high from first to last count
   localparam logic [2:0] ULPI_DIV_LAST = 3'h5;
   localparam logic [2:0] ULPI_HI_FIRST = 3'h1;
   localparam logic [2:0] ULPI_HI_LAST = 3'h3;

endpackage

// ==== tb/ulh_phy_model.sv ====
`timescale 1ns/1ps
module ulh_phy_model (
   input wire logic uclk,
   input wire logic rst,
   input wire logic stp,
   input wire ulh_pkg::ulh_byte_t dout,
   input wire logic oe,
   input wire logic rx_req,
   input wire ulh_pkg::ulh_byte_t rx_byte,
   output logic dir,
   output logic nxt,
   output ulh_pkg::ulh_byte_t bus,
   output logic err,
   output ulh_pkg::ulh_byte_t tx_cmd,
   output ulh_pkg::ulh_byte_t tx_byte
);
   import ulh_pkg::*;
   ulh_byte_t mem [256];
   ulh_byte_t cmd, q0, q1, pdata, last;
   logic got, pend, rq_q, dir_q, stp_q, rxd;
   int st, cnt;
   wire ulh_byte_t ra = (cmd[5:0] == EXT_ADDR) ? q0 : {2'b00, cmd[5:0]};
   // a released bus shows the inverse of its last level
   assign bus = dir ? pdata : (oe ? dout : ~last);
   always @(posedge uclk or posedge rst) begin
      if (rst) begin
         st <= 5;
         dir <= 1'b1;
         nxt <= 1'b0;
         cnt <= 0;
         pend <= 1'b0;
         rq_q <= 1'b0;
         err <= 1'b0;
         pdata <= 8'h00;
         last <= 8'h00;
      end else begin
         rq_q <= rx_req;
         stp_q <= stp;
         dir_q <= dir;
         last <= bus;
         if (rx_req && !rq_q) pend <= 1'b1;
         if (stp && stp_q) err <= 1'b1;
         if (dir && dir_q && oe) err <= 1'b1;
         case (st)
            5: begin
               cnt <= cnt + 1;
               if (cnt == 3) begin
                  dir <= 1'b0;
                  st <= 0;
               end
            end
            0: if (pend) begin
               pend <= 1'b0;
               dir <= 1'b1;
               rxd <= 1'b1;
               pdata <= ~last;
               st <= 3;
            end else if (bus != IDLE_BYTE) begin
               cmd <= bus;
               nxt <= 1'b1;
               got <= 1'b0;
               st <= (bus[7:6] == OP_RD) ? 2 : 1;
            end
            1: if (stp) begin
               nxt <= 1'b0;
               st <= 0;
               if (cmd[7:6] == OP_WR) mem[ra] <= q1;
               else tx_cmd <= cmd;
               if (cmd[7:6] != OP_WR) tx_byte <= q1;
            end else begin
               if (!got) q0 <= bus;
               got <= 1'b1;
               q1 <= bus;
            end
            2: if (cmd[5:0] == EXT_ADDR && !got) begin
               q0 <= bus;
               got <= 1'b1;
            end else begin
               nxt <= 1'b0;
               dir <= 1'b1;
               rxd <= 1'b0;
               pdata <= ~last;
               st <= 3;
            end
            3: begin
               pdata <= rxd ? rx_byte : mem[ra];
               st <= 4;
            end
            default: begin
               dir <= 1'b0;
               pdata <= ~pdata;
               st <= 0;
            end
         endcase
      end
   end
endmodule

// ==== tb/ulh_link_tb_top.sv ====
`timescale 1ns/1ps
module ulh_link_tb_top;
   import ulh_pkg::*;
   logic core_clk, rst, psel, penable, pwrite, rx_req, pready, pslverr, clk_o, clk_oe, dir, nxt, d_oe, stp, err, er;
   ulh_addr_t paddr;
   ulh_word_t pwdata, prdata, rd, sts;
   ulh_byte_t d_i, d_o, rx_byte, tx_cmd, tx_byte;
   ulh_byte_t shadow [256];
   ulh_byte_t addrs [12];
   localparam ulh_byte_t EDGE [6] = '{8'h00, 8'h2E, 8'h2F, 8'h30, 8'hC0, 8'hFF};
   logic [31:0] seed = 32'hCC2E;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   ulh_link u_ulh_link (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ULPI_CLK_I(1'b0), .ULPI_CLK_O(clk_o), .ULPI_CLK_OE(clk_oe), .ULPI_DIR(dir), .ULPI_NXT(nxt),
      .ULPI_DATA_I(d_i), .ULPI_DATA_O(d_o), .ULPI_DATA_OE(d_oe), .ULPI_STP(stp));
   ulh_phy_model u_ulh_phy_model (.uclk(clk_o), .rst(rst), .stp(stp), .dout(d_o), .oe(d_oe), .rx_req(rx_req),
      .rx_byte(rx_byte), .dir(dir), .nxt(nxt), .bus(d_i), .err(err), .tx_cmd(tx_cmd), .tx_byte(tx_byte));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input ulh_addr_t a, input ulh_word_t d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[STS_DONE] !== 1'b1 && n < 400) begin
         apb(1'b0, REG_STATUS, 32'h0);
         n++;
      end
      sts = rd;
      chk(32'(rd[STS_BUSY]), 32'h0);
      apb(1'b1, REG_STATUS, 32'h2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rx_req = 1'b0;
      rx_byte = 8'h00;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (12) @(posedge core_clk);
      chk(32'(d_oe), 32'h0);
      repeat (30) @(posedge core_clk);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, REG_STATUS, 32'h6);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rd[7:0]), 32'h0);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         addrs[i] = (i < 6) ? EDGE[i] : seed[15:8];
         shadow[addrs[i]] = seed[7:0];
         apb(1'b1, REG_CMD, {8'h00, seed[7:0], addrs[i], 6'h00, OP_WR});
         if (i == 0) apb(1'b1, REG_CMD, 32'h0000_0001);
         if (i == 0) chk(32'(er), 32'h1);
         wait_done();
         chk(32'(u_ulh_phy_model.mem[addrs[i]]), 32'(seed[7:0]));
      end
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         apb(1'b1, REG_CMD, {8'h00, seed[23:16], 4'h0, seed[3:0], 6'h00, OP_TX});
         wait_done();
         chk(32'(tx_cmd), 32'({OP_TX, 2'b00, seed[3:0]}));
         chk(32'(tx_byte), 32'(seed[23:16]));
      end
      for (int i = 0; i < 2; i++) begin
         seed = lfsr(seed);
         rx_byte <= seed[7:0] | 8'h01;
         rx_req <= 1'b1;
         if (i == 1) shadow[8'h11] = seed[15:8];
         if (i == 1) apb(1'b1, REG_CMD, {8'h00, seed[15:8], 8'h11, 6'h00, OP_WR});
         if (i == 1) wait_done();
         if (i == 1) chk(32'(u_ulh_phy_model.mem[8'h11]), 32'(seed[15:8]));
         repeat (60) @(posedge core_clk);
         rx_req <= 1'b0;
         apb(1'b0, REG_STATUS, 32'h0);
         chk({rd[23:16], 7'h00, rd[STS_RXV]}, {seed[7:0] | 8'h01, 8'h01});
         apb(1'b1, REG_STATUS, 32'h4);
         apb(1'b0, REG_STATUS, 32'h0);
         chk(32'(rd[STS_RXV]), 32'h0);
      end
      chk(32'(err), 32'h0);
      apb(1'b1, REG_CTRL, 32'h4);
      chk(32'(stp), 32'h1);
      apb(1'b1, REG_CTRL, 32'h2);
      repeat (8) @(posedge core_clk);
      sts = 32'(clk_o);
      repeat (12) @(posedge core_clk);
      chk(32'(clk_o), sts);
      apb(1'b1, REG_CTRL, 32'h1);
      chk(32'(clk_oe), 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, REG_CTRL, 32'h0);
      chk(32'(clk_oe), 32'h1);
      repeat (30) @(posedge core_clk);
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, REG_CMD, {16'h0000, addrs[i], 6'h00, OP_RD});
         wait_done();
         chk(32'(sts[STS_RDATA_LSB +: 8]), 32'(shadow[addrs[i]]));
      end
      give_verdict();
   end
endmodule
